// file: design/ssc_sleep_ctrl.sv
`timescale 1ns/1ps
`include "ssc_defines.svh"
module ssc_sleep_ctrl (
  input  wire logic                   clk_i,
  input  wire logic                   rstn_i,
  input  wire logic                   sleep_request_i,
  input  wire logic                   select_i,
  input  wire logic [1:0]             cmd_i,
  input  wire logic [`SSC_ADDR_W-1:0] addr_i,
  input  wire logic [`SSC_DATA_W-1:0] wdata_i,
  input  wire logic                   out_en_i,
  output logic      [`SSC_DATA_W-1:0] dq_o,
  output logic                        dq_oe_o,
  output logic                        asleep_o,
  output logic                        recovering_o,
  output logic                        write_refused_o
);
  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  // --------------------------------------------------------------------------
  // Sleep sequencer
  // --------------------------------------------------------------------------
  ssc_pkg::ssc_state_t state_q;
  ssc_pkg::ssc_state_t state_d;
  logic [`SSC_CNT_W-1:0] cnt_q;
  logic [`SSC_CNT_W-1:0] cnt_d;

  // The request is sampled once per edge; the host meets setup and hold so a
  // single register is safe and keeps entry at exactly two cycles.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      // A low or released request keeps the sequencer awake; the pin's pull-down sits outside this logic.
      ssc_pkg::SSC_AWAKE: begin
        if (sleep_request_i) begin
          state_d = ssc_pkg::SSC_ENTERING;
          cnt_d   = `SSC_CNT_W'(1);
        end
      end
      ssc_pkg::SSC_ENTERING: begin
        if (!sleep_request_i) begin
          state_d = ssc_pkg::SSC_AWAKE;
        end else if (cnt_q >= `SSC_ENTRY_CYCLES - 3'd1) begin
          state_d = ssc_pkg::SSC_ASLEEP;
        end else begin
          cnt_d = cnt_q + 3'd1;
        end
      end
      ssc_pkg::SSC_ASLEEP: begin
        if (!sleep_request_i) begin
          state_d = ssc_pkg::SSC_RECOVERING;
          cnt_d   = `SSC_CNT_W'(1);
        end
      end
      ssc_pkg::SSC_RECOVERING: begin
        if (sleep_request_i) begin
          state_d = ssc_pkg::SSC_ENTERING;
          cnt_d   = `SSC_CNT_W'(1);
        end else if (cnt_q >= `SSC_CNT_W'(`SSC_RECOVERY_CYCLES)) begin
          state_d = ssc_pkg::SSC_AWAKE;
        end else begin
          cnt_d = cnt_q + 3'd1;
        end
      end
      default: begin
        state_d = ssc_pkg::SSC_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ssc_pkg::SSC_AWAKE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  logic asleep;
  logic recov;
  assign asleep = (state_q == ssc_pkg::SSC_ASLEEP);
  assign recov  = (state_q == ssc_pkg::SSC_RECOVERING);

  // --------------------------------------------------------------------------
  // Command gating and data path
  // --------------------------------------------------------------------------
  logic wr_cmd;
  logic wr_ok;
  logic rd_ok;
  assign wr_cmd = select_i && (cmd_i == 2'(ssc_pkg::SSC_CMD_WRITE));
  // Asleep, every input but the request is ignored; a write during recovery
  // is dropped and flagged rather than risk corrupting the array.
  assign wr_ok = wr_cmd && !asleep && !recov;
  assign rd_ok = select_i && (cmd_i == 2'(ssc_pkg::SSC_CMD_READ)) && !asleep;

  logic [`SSC_DATA_W-1:0] rdata;
  ssc_store u_store (
    .clk_i   (clk_i),
    .wr_en_i (wr_ok),
    .addr_i  (addr_i),
    .wdata_i (wdata_i),
    .rdata_o (rdata)
  );

  logic rd_pend_q;
  logic rd_pend_d;
  logic oe_q;
  logic oe_d;
  logic wref_q;
  logic wref_d;
  // The array read port follows the address every cycle, so the word is caught
  // when its read is due; a later address change would otherwise replace it.
  logic [`SSC_DATA_W-1:0] dq_q;
  logic [`SSC_DATA_W-1:0] dq_d;

  always_comb begin
    rd_pend_d = rd_ok;
    oe_d      = rd_pend_q && out_en_i && !asleep && (state_d != ssc_pkg::SSC_ASLEEP);
    wref_d    = wr_cmd && recov;
    dq_d      = rd_pend_q ? rdata : dq_q;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rd_pend_q <= 1'b0;
      oe_q      <= 1'b0;
      wref_q    <= 1'b0;
      dq_q      <= '0;
    end else begin
      rd_pend_q <= rd_pend_d;
      oe_q      <= oe_d;
      wref_q    <= wref_d;
      dq_q      <= dq_d;
    end
  end

  assign dq_o            = dq_q;
  assign dq_oe_o         = oe_q;
  assign asleep_o        = asleep;
  assign recovering_o    = recov;
  assign write_refused_o = wref_q;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  sequence s_req_held2;
    sleep_request_i [*2];
  endsequence

  sequence s_wake;
    asleep && !sleep_request_i;
  endsequence

  sequence s_read_served;
    rd_ok ##1 (out_en_i && (state_q == ssc_pkg::SSC_AWAKE));
  endsequence

  a_sleep_entry: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state_q == ssc_pkg::SSC_AWAKE) ##0 s_req_held2 |=> asleep)
    else $error("Sleep not entered two cycles after request.");

  a_no_early_sleep: assert property (@(posedge clk_i) disable iff (!rst_n)
    !sleep_request_i && !asleep |=> !asleep)
    else $error("Sleep entered without a request.");

  a_outputs_hiz: assert property (@(posedge clk_i) disable iff (!rst_n)
    asleep |-> !dq_oe_o)
    else $error("Outputs driven while asleep.");

  a_no_sleep_write: assert property (@(posedge clk_i) disable iff (!rst_n)
    (asleep || recov) |-> !wr_ok)
    else $error("Array written during sleep or recovery.");

  // One clock of recovery already exceeds the minimum at this clock rate.
  a_recovery_len: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_wake |=> recov)
    else $error("Recovery shorter than required.");

  a_recovery_ends: assert property (@(posedge clk_i) disable iff (!rst_n)
    recov && !sleep_request_i |=> (state_q == ssc_pkg::SSC_AWAKE))
    else $error("Recovery did not end in time.");

  a_write_flag: assert property (@(posedge clk_i) disable iff (!rst_n)
    recov && wr_cmd |=> write_refused_o)
    else $error("Refused write not flagged.");

  a_state_kept: assert property (@(posedge clk_i) disable iff (!rst_n)
    asleep |=> $stable(cnt_q) || !asleep)
    else $error("Sequencer state disturbed in sleep.");

  a_entry_step: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state_q == ssc_pkg::SSC_AWAKE) && sleep_request_i |=> !asleep)
    else $error("Sleep entered one cycle after request.");

  a_awake_low: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state_q == ssc_pkg::SSC_AWAKE) && !sleep_request_i |=> (state_q == ssc_pkg::SSC_AWAKE))
    else $error("Sequencer left awake with request low.");

  a_entry_abort: assert property (@(posedge clk_i) disable iff (!rst_n)
    (state_q == ssc_pkg::SSC_ENTERING) && !sleep_request_i |=> (state_q == ssc_pkg::SSC_AWAKE))
    else $error("Entry not abandoned when request fell.");

  a_read_drive: assert property (@(posedge clk_i) disable iff (!rst_n)
    s_read_served |=> dq_oe_o)
    else $error("Read data not driven when due.");
endmodule

// file: design/ssc_defines.svh
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH
// What this block does
// - Sleep begins two clock cycles after the sleep request rises.
// - Sleep request is active high, asynchronous, and is what places the device asleep; the block samples it on the clock edge with no synchronizer.
// - Internal state is kept intact throughout sleep and reused on wake.
// - Asleep: deselected, all inputs but the request ignored, outputs high impedance.
// - Sleep request stays low in normal use; undriven it is pulled low.
// - Normal operation resumes only after at least 20 ns recovery; the block refuses only writes during recovery and still serves reads.

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SSC_CLK_PERIOD_PS    32'd25000
`define SSC_ENTRY_CYCLES     3'd2
`define SSC_RECOVERY_TIME_NS 32'd20
`define SSC_RECOVERY_CYCLES  ((`SSC_RECOVERY_TIME_NS * 32'd1000 + `SSC_CLK_PERIOD_PS - 32'd1) / `SSC_CLK_PERIOD_PS)

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define SSC_ADDR_W 8
`define SSC_DATA_W 18
`define SSC_CNT_W  3
`endif

// file: design/ssc_pkg.sv
package ssc_pkg;
  typedef enum logic [1:0] {
    SSC_CMD_DESELECT,
    SSC_CMD_READ,
    SSC_CMD_WRITE,
    SSC_CMD_NOP
  } ssc_cmd_t;

  typedef enum {
    SSC_AWAKE,
    SSC_ENTERING,
    SSC_ASLEEP,
    SSC_RECOVERING
  } ssc_state_t;
endpackage

// file: design/ssc_store.sv
`timescale 1ns/1ps
`include "ssc_defines.svh"
module ssc_store (
  input  wire logic                   clk_i,
  input  wire logic                   wr_en_i,
  input  wire logic [`SSC_ADDR_W-1:0] addr_i,
  input  wire logic [`SSC_DATA_W-1:0] wdata_i,
  output logic      [`SSC_DATA_W-1:0] rdata_o
);
  logic [`SSC_DATA_W-1:0] mem_q [0:(1<<`SSC_ADDR_W)-1];
  logic [`SSC_DATA_W-1:0] rdata_q;

  // Contents hold whatever the power state; there is no reset on the array.
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_q <= mem_q[addr_i];
  end

  assign rdata_o = rdata_q;
endmodule

// file: tb/ssc_host.sv
`timescale 1ns/1ps
`include "ssc_defines.svh"
module ssc_host (
  input  wire logic                   clk_i,
  input  wire logic                   sleep_i,
  input  wire logic                   strict_i,
  input  wire logic [1:0]             cmd_i,
  input  wire logic [`SSC_ADDR_W-1:0] addr_i,
  output logic                        sleep_request_o,
  output logic                        select_o,
  output logic      [1:0]             cmd_o,
  output logic      [`SSC_ADDR_W-1:0] addr_o
);
  logic                   req_q = 1'b0;
  logic [2:0]             hold_q = 3'h0;
  logic [`SSC_ADDR_W-1:0] last_q = 8'h00;
  logic                   wr_block;

  // Clearing strict_i lets a scenario push a write into recovery on purpose.
  assign wr_block = strict_i && (hold_q != 3'h0) && (cmd_i == ssc_pkg::SSC_CMD_WRITE);
  assign cmd_o = wr_block ? ssc_pkg::SSC_CMD_DESELECT : cmd_i;
  assign select_o = (cmd_o != ssc_pkg::SSC_CMD_DESELECT);
  // An unselected address bus shows the inverse of its last value, never a stale copy.
  assign addr_o = select_o ? addr_i : ~last_q;
  assign sleep_request_o = req_q;

  always_ff @(posedge clk_i) begin
    if (select_o) begin
      last_q <= addr_i;
    end
    req_q <= sleep_i && (req_q || !select_o);
    if (req_q && !sleep_i) begin
      hold_q <= 3'(`SSC_RECOVERY_CYCLES + 32'd1);
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end
  end
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
`include "ssc_defines.svh"
module tb;
  logic                   clk_i = 1'b0;
  logic                   rstn_i = 1'b0;
  logic                   slp = 1'b0;
  logic                   strict = 1'b1;
  logic [1:0]             cmd = 2'h0;
  logic [`SSC_ADDR_W-1:0] addr = 8'h00;
  logic [`SSC_DATA_W-1:0] wd = 18'h00000;
  logic [`SSC_DATA_W-1:0] dq;
  logic                   req, sel, oe, asl, rec, wref;
  logic [1:0]             hcmd;
  logic [`SSC_ADDR_W-1:0] haddr;
  int                     num_errors = 0;
  int                     samples_checked = 0;

  ssc_host host (.clk_i(clk_i), .sleep_i(slp), .strict_i(strict), .cmd_i(cmd), .addr_i(addr),
    .sleep_request_o(req), .select_o(sel), .cmd_o(hcmd), .addr_o(haddr));
  ssc_sleep_ctrl dut (.clk_i(clk_i), .rstn_i(rstn_i), .sleep_request_i(req), .select_i(sel), .cmd_i(hcmd),
    .addr_i(haddr), .wdata_i(wd), .out_en_i(1'b1), .dq_o(dq), .dq_oe_o(oe), .asleep_o(asl),
    .recovering_o(rec), .write_refused_o(wref));

  initial forever #12.5 clk_i = ~clk_i;

  task automatic chk(string n, logic [17:0] seen, logic [17:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic op(logic [1:0] c, logic [7:0] a, logic [17:0] d);
    @(posedge clk_i);
    cmd <= c;
    addr <= a;
    wd <= d;
    @(posedge clk_i);
    cmd <= 2'h0;
  endtask

  task automatic sleep_cycle();
    op(2'h2, 8'h05, 18'h2a5c3);
    slp <= 1'b1;
    for (int i = 0; i < 8 && req !== 1'b1; i++) @(negedge clk_i);
    @(negedge clk_i);
    chk("asleep early", asl, 18'h0);
    repeat (2) @(negedge clk_i);
    chk("asleep", asl, 18'h1);
    op(2'h2, 8'h05, 18'h00bad);
    op(2'h1, 8'h05, 18'h0);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("drive while asleep", oe, 18'h0);
    @(posedge clk_i);
    slp <= 1'b0;
    strict <= 1'b0;
    repeat (2) @(posedge clk_i);
    cmd <= 2'h2;
    wd <= 18'h11111;
    @(negedge clk_i);
    chk("recovering", rec, 18'h1);
    @(posedge clk_i);
    cmd <= 2'h0;
    @(negedge clk_i);
    chk("write refused", wref, 18'h1);
    repeat (6) @(negedge clk_i);
    chk("recovery over", rec, 18'h0);
    strict <= 1'b1;
    op(2'h1, 8'h05, 18'h0);
    @(posedge clk_i);
    @(negedge clk_i);
    chk("read enable", oe, 18'h1);
    chk("kept data", dq, 18'h2a5c3);
  endtask

  task automatic abort_entry();
    @(posedge clk_i);
    slp <= 1'b1;
    @(posedge clk_i);
    slp <= 1'b0;
    repeat (3) @(negedge clk_i);
    chk("aborted entry", asl, 18'h0);
    chk("no recovery", rec, 18'h0);
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    sleep_cycle();
    abort_entry();
    complete_run();
  end

  initial begin
    #(25 * 400);
    num_errors++;
    complete_run();
  end
endmodule
